// >>> serial_port_pkg.sv
// Constants shared by the byte-wide serial port: register map, field positions,
// reset values, master clock divider codes and the transfer state encoding.
// Assumes a 100 MHz pclk and an APB master with an 8-bit byte address.
package serial_port_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int        APB_ADDR_W = 8;
  localparam logic [7:0] IDX_DATA  = 8'h31;
  localparam logic [7:0] IDX_CTRL  = 8'h32;
  localparam logic [7:0] IDX_STAT  = 8'h33;
  localparam logic [7:0] ADDR_DATA = {IDX_DATA[5:0], 2'b00};
  localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_STAT = {IDX_STAT[5:0], 2'b00};

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int CTRL_IRQ_EN  = 7;
  localparam int CTRL_PORT_EN = 6;
  localparam int CTRL_RATE_DE = 5;
  localparam int CTRL_MASTER  = 4;
  localparam int CTRL_CLOCK_POLARITY    = 3;
  localparam int CTRL_CLOCK_PHASE    = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================================
  // Control/status register fields
  // ==========================================================================
  localparam int STAT_TC      = 7;
  localparam int STAT_WRITE_COLLISION_FLAG    = 6;
  localparam int STAT_OVR     = 5;
  localparam int STAT_MODE_FAULT_FLAG    = 4;
  localparam int STAT_SOD     = 2;
  localparam int STAT_SSM     = 1;
  localparam int STAT_SSI     = 0;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ==========================================================================
  // Master clock divider: code is {rate_divider_enable, hi, lo}
  // ==========================================================================
  localparam logic [7:0] SCK_DIV_4   = 8'h04;
  localparam logic [7:0] SCK_DIV_8   = 8'h08;
  localparam logic [7:0] SCK_DIV_16  = 8'h10;
  localparam logic [7:0] SCK_DIV_32  = 8'h20;
  localparam logic [7:0] SCK_DIV_64  = 8'h40;
  localparam logic [7:0] SCK_DIV_128 = 8'h80;
  localparam logic [3:0] LAST_EDGE   = 4'hf;

  // Half period in pclk cycles; undefined codes fall back to the slowest rate.
  function automatic logic [6:0] rate_half(input logic [2:0] code);
    logic [7:0] div;
    div = SCK_DIV_128;
    case (code)
      3'b100:  div = SCK_DIV_4;
      3'b000:  div = SCK_DIV_8;
      3'b001:  div = SCK_DIV_16;
      3'b110:  div = SCK_DIV_32;
      3'b010:  div = SCK_DIV_64;
      3'b011:  div = SCK_DIV_128;
      default: div = SCK_DIV_128;
    endcase
    return div[7:1];
  endfunction : rate_half

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } xfer_state_t;

endpackage : serial_port_pkg

// >>> pin_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level; no bus coherency is provided.
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pin_sync

// >>> serial_port.sv
// Byte-wide synchronous serial port, master or slave, with an APB register port.
// Assumes zero-wait APB, pins resolved outside from the output enables, and in
// slave mode an external serial clock no faster than pclk/8.
// What this block does
// R1 - Interrupt request is high when enabled and completion, overrun or fault is set.
// R2 - Select low in master mode clears port enable and master; reset clears enable.
// R3 - Port enable off releases the pins; on claims them for the serial port.
// R4 - Master clock is pclk divided by 4 to 128 from the three rate bits.
// R5 - In slave mode the rate bits are ignored; the clock comes from outside.
// R6 - Master drives the clock pin and swaps data pin roles against slave mode.
// R7 - Clock polarity sets the idle level of the serial clock in both modes.
// R8 - Clock phase picks the first or the second clock edge as capture edge.
// R9 - Software disables the port before changing clock polarity between bytes.
// R10 - The far slave uses the same polarity and phase settings as the master.
// R11 - Completion flag sets at byte end; clears after status access then data access.
// R12 - Data writes are ignored while completion is set and status has not been accessed.
// R13 - Writing data during a transfer sets the write collision flag.
// R14 - Byte ending while completion is set raises overrun; status read clears it.
// R15 - Select low in master mode sets fault; status access then control write clears.
// R16 - Output disable disconnects the serial data output in both modes.
// R17 - Software select management ignores the select pin and uses the internal bit.
// R18 - Internal select bit zero means selected, one means deselected.
// R19 - In master mode a data write starts one byte out and one byte in.
// R20 - Received byte is copied to a buffer at completion unless overrun is raised; data reads return it.
// R21 - A data write loads the byte straight into the shift register.
// R22 - Software keeps the reserved status bit three written as zero.
// R23 - Eight bits shift per byte, most significant first, on the chosen edges.
module serial_port
  import serial_port_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  sck_in,
  output logic                       sck_out,
  output logic                       sck_oe,
  input  wire logic                  mosi_in,
  output logic                       mosi_out,
  output logic                       mosi_oe,
  input  wire logic                  miso_in,
  output logic                       miso_out,
  output logic                       miso_oe,
  input  wire logic                  ss_n_in,
  output logic                       pins_alt_en,
  output logic                       ss_alt_en,
  output logic                       irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic        irq_en_r, port_en_r, rate_de_r, master_r;
  logic        clock_polarity_r, clock_phase_r, rate_hi_r, rate_lo_r;
  logic        tc_r, write_collision_flag_r, ovr_r, mode_fault_flag_r, sod_r, ssm_r, ssi_r;
  logic        arm_tc_r, arm_write_collision_flag_r, arm_mode_fault_flag_r;
  logic [7:0]  rxbuf_r;
  logic [7:0]  shift_r;
  logic        out_r;
  logic [3:0]  edge_cnt_r;
  logic [6:0]  div_cnt_r;
  logic        sck_lvl_r;
  logic        sck_prev_r;
  logic        m_lead_r, m_trail_r;
  logic [7:0]  prdata_r;
  xfer_state_t state_r;
  xfer_state_t state_nxt;

  logic [3:0]  sync_q;
  logic        sck_s, mosi_s, miso_s, ss_n_s;

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({sck_in, mosi_in, miso_in, ss_n_in}),
    .q       (sync_q)
  );

  assign sck_s  = sync_q[3];
  assign mosi_s = sync_q[2];
  assign miso_s = sync_q[1];
  assign ss_n_s = sync_q[0];

  // ==========================================================================
  // APB decode
  // ==========================================================================
  wire       acc       = psel & penable;
  wire       sel_data  = (paddr == ADDR_DATA);
  wire       sel_ctrl  = (paddr == ADDR_CTRL);
  wire       sel_stat  = (paddr == ADDR_STAT);
  wire       hit       = sel_data | sel_ctrl | sel_stat;
  wire       wr_lane   = acc & pwrite & pstrb[0];
  wire       data_acc  = acc & sel_data;
  wire       data_wr   = wr_lane & sel_data;
  wire       ctrl_wr   = wr_lane & sel_ctrl;
  wire       stat_wr   = wr_lane & sel_stat;
  wire       stat_acc  = acc & sel_stat;
  wire       stat_rd   = stat_acc & !pwrite;

  wire [7:0] ctrl_val  = {irq_en_r, port_en_r, rate_de_r, master_r,
                          clock_polarity_r, clock_phase_r, rate_hi_r, rate_lo_r};
  wire [7:0] stat_val  = {tc_r, write_collision_flag_r, ovr_r, mode_fault_flag_r, 1'b0, sod_r, ssm_r, ssi_r};
  wire [7:0] rd_mux    = sel_data ? rxbuf_r :  // [R20]
                         sel_ctrl ? ctrl_val :
                         sel_stat ? stat_val : 8'h00;

  assign pready  = 1'b1;
  assign pslverr = acc & !hit;
  assign prdata  = {24'h000000, prdata_r};

  // ==========================================================================
  // Select, fault and transfer control
  // ==========================================================================
  wire       selected  = ssm_r ? !ssi_r : !ss_n_s;  // [R17] [R18]
  wire       fault     = master_r & port_en_r & selected;  // [R2] [R15]
  wire       running   = (state_r == ST_RUN);
  wire       busy      = running | (edge_cnt_r != 4'h0);
  wire       wr_block  = tc_r & !arm_tc_r;  // [R12]
  wire       load_ok   = data_wr & !busy & !wr_block;
  wire       collide   = data_wr & busy;  // [R13]
  wire       start_m   = load_ok & master_r & port_en_r;  // [R19]
  wire       slave_on  = port_en_r & !master_r & selected;

  // Master clock generator, rate bits read here and in the control register readback.
  wire [6:0] half      = rate_half({rate_de_r, rate_hi_r, rate_lo_r});  // [R4] [R5]
  wire       div_tick  = running & (div_cnt_r == (half - 7'd1));
  wire       m_lead    = div_tick & (sck_lvl_r == clock_polarity_r);
  wire       m_trail   = div_tick & (sck_lvl_r != clock_polarity_r);

  // Slave edges seen on the synchronised external clock.
  wire       s_edge    = slave_on & (sck_s != sck_prev_r);
  wire       s_lead    = s_edge & (sck_s != clock_polarity_r);  // [R7]
  wire       s_trail   = s_edge & (sck_s == clock_polarity_r);

  // Master events act one cycle after the clock toggle, so the returning data bit
  // has crossed the pin synchroniser even at the fastest rate.
  wire       lead_p    = master_r ? m_lead_r : s_lead;
  wire       trail_p   = master_r ? m_trail_r : s_trail;
  wire       capture_p = clock_phase_r ? trail_p : lead_p;  // [R8]
  wire       shift_p   = clock_phase_r ? lead_p : trail_p;  // [R8]
  wire       any_edge  = lead_p | trail_p;
  wire       serial_in = master_r ? miso_s : mosi_s;  // [R6]
  wire [7:0] shift_cap = {shift_r[6:0], serial_in};  // [R23]
  wire       done_p    = any_edge & (edge_cnt_r == LAST_EDGE);  // [R23]
  wire [7:0] rx_byte   = capture_p ? shift_cap : shift_r;
  wire       abort     = !port_en_r | (master_r ? !running : !selected);

  // Flag clear conditions; hardware set always wins below.
  wire       tc_clr    = arm_tc_r & data_acc;  // [R11]
  wire       ovr_set   = done_p & tc_r & !tc_clr;  // [R14]
  wire       mode_fault_flag_lock = mode_fault_flag_r & !arm_mode_fault_flag_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (start_m)
          state_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        if (done_p | !port_en_r | !master_r)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Serial engine
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= ST_IDLE;
      div_cnt_r  <= 7'h00;
      sck_lvl_r  <= 1'b0;
      sck_prev_r <= 1'b0;
      edge_cnt_r <= 4'h0;
      m_lead_r   <= 1'b0;
      m_trail_r  <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      sck_prev_r <= sck_s;
      m_lead_r   <= m_lead;  // [R8]
      m_trail_r  <= m_trail;  // [R8]
      div_cnt_r  <= (running & !div_tick) ? div_cnt_r + 7'd1 : 7'h00;
      if (!running)
        sck_lvl_r <= clock_polarity_r;  // [R7]
      else if (div_tick)
        sck_lvl_r <= !sck_lvl_r;  // [R4]
      if (abort | done_p)
        edge_cnt_r <= 4'h0;
      else if (any_edge)
        edge_cnt_r <= edge_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_r <= DATA_RESET;
      out_r   <= 1'b0;
    end
    else if (load_ok)
    begin
      shift_r <= pwdata[7:0];  // [R21]
      out_r   <= pwdata[7];
    end
    else
    begin
      if (capture_p)
        shift_r <= shift_cap;  // [R23]
      if (shift_p)
        out_r <= shift_r[7];  // [R23]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rxbuf_r <= DATA_RESET;
    else if (done_p & !ovr_set)
      rxbuf_r <= rx_byte;  // [R20] [R14]
  end

  // ==========================================================================
  // Status flags
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tc_r       <= STAT_RESET[STAT_TC];
      write_collision_flag_r     <= STAT_RESET[STAT_WRITE_COLLISION_FLAG];
      ovr_r      <= STAT_RESET[STAT_OVR];
      mode_fault_flag_r     <= STAT_RESET[STAT_MODE_FAULT_FLAG];
      arm_tc_r   <= 1'b0;
      arm_write_collision_flag_r <= 1'b0;
      arm_mode_fault_flag_r <= 1'b0;
    end
    else
    begin
      tc_r       <= done_p | (tc_r & !tc_clr);  // [R11]
      arm_tc_r   <= !done_p & ((stat_acc & tc_r) | (arm_tc_r & !data_acc));  // [R11]
      write_collision_flag_r     <= collide | (write_collision_flag_r & !(arm_write_collision_flag_r & data_acc));  // [R13]
      arm_write_collision_flag_r <= !collide & ((stat_acc & write_collision_flag_r) | (arm_write_collision_flag_r & !data_acc));
      ovr_r      <= ovr_set | (ovr_r & !stat_rd);  // [R14]
      mode_fault_flag_r     <= fault | (mode_fault_flag_r & !(arm_mode_fault_flag_r & ctrl_wr));  // [R15]
      arm_mode_fault_flag_r <= !fault & ((stat_acc & mode_fault_flag_r) | (arm_mode_fault_flag_r & !ctrl_wr));  // [R15]
    end
  end

  // ==========================================================================
  // Control and software-owned status bits
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_en_r  <= CTRL_RESET[CTRL_IRQ_EN];
      port_en_r <= CTRL_RESET[CTRL_PORT_EN];  // [R2]
      rate_de_r <= CTRL_RESET[CTRL_RATE_DE];
      master_r  <= CTRL_RESET[CTRL_MASTER];
      clock_polarity_r    <= CTRL_RESET[CTRL_CLOCK_POLARITY];
      clock_phase_r    <= CTRL_RESET[CTRL_CLOCK_PHASE];
      rate_hi_r <= CTRL_RESET[CTRL_RATE_HI];
      rate_lo_r <= CTRL_RESET[CTRL_RATE_LO];
    end
    else
    begin
      if (ctrl_wr)
      begin
        irq_en_r  <= pwdata[CTRL_IRQ_EN];
        rate_de_r <= pwdata[CTRL_RATE_DE];
        clock_polarity_r    <= pwdata[CTRL_CLOCK_POLARITY];
        clock_phase_r    <= pwdata[CTRL_CLOCK_PHASE];
        rate_hi_r <= pwdata[CTRL_RATE_HI];
        rate_lo_r <= pwdata[CTRL_RATE_LO];
      end
      // A pending fault blocks enabling until its clearing sequence runs.
      if (fault)
      begin
        port_en_r <= 1'b0;  // [R2]
        master_r  <= 1'b0;  // [R2]
      end
      else if (ctrl_wr)
      begin
        port_en_r <= pwdata[CTRL_PORT_EN] & !mode_fault_flag_lock;
        master_r  <= pwdata[CTRL_MASTER] & !mode_fault_flag_lock;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sod_r <= STAT_RESET[STAT_SOD];
      ssm_r <= STAT_RESET[STAT_SSM];
      ssi_r <= STAT_RESET[STAT_SSI];
    end
    else if (stat_wr)
    begin
      sod_r <= pwdata[STAT_SOD];
      ssm_r <= pwdata[STAT_SSM];
      ssi_r <= pwdata[STAT_SSI];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 8'h00;
    else if (psel & !penable)
      prdata_r <= rd_mux;
  end

  // ==========================================================================
  // Pins and interrupt
  // ==========================================================================
  assign pins_alt_en = port_en_r;  // [R3]
  assign ss_alt_en   = port_en_r & !ssm_r;  // [R17]
  assign sck_out     = sck_lvl_r;
  assign sck_oe      = port_en_r & master_r;  // [R3] [R6]
  assign mosi_out    = out_r;
  assign mosi_oe     = port_en_r & master_r & !sod_r;  // [R6] [R16]
  assign miso_out    = out_r;
  assign miso_oe     = port_en_r & !master_r & !sod_r & selected;  // [R6] [R16]
  assign irq         = irq_en_r & (tc_r | ovr_r | mode_fault_flag_r);  // [R1]

endmodule : serial_port

// >>> serial_port_assertions.sv
// Concurrent checks on the serial port's pins and register bus.
// Bound into serial_port below; it sees only that module's ports.
module serial_port_assertions
  import serial_port_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire logic                  sck_out,
  input wire logic                  sck_oe,
  input wire logic                  mosi_oe,
  input wire logic                  miso_oe,
  input wire logic                  ss_n_in,
  input wire logic                  pins_alt_en,
  input wire logic                  ss_alt_en,
  input wire logic                  irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mapped;
  assign mapped = (paddr == ADDR_DATA) || (paddr == ADDR_CTRL) || (paddr == ADDR_STAT);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_pins_need_port:
    assert property ((sck_oe || mosi_oe || miso_oe || ss_alt_en) |-> pins_alt_en)
    else $error("serial pin claimed while the port is disabled");
  a_roles_exclusive:
    assert property (!(sck_oe && miso_oe))
    else $error("clock output and slave data output driven together");
  a_mosi_master_only:
    assert property (mosi_oe |-> sck_oe)
    else $error("master data output driven outside master mode");
  a_fault_drops_master:
    assert property (sck_oe && ss_alt_en && !ss_n_in ##1 !ss_n_in [*3] |-> ##[0:2] !sck_oe)
    else $error("master kept driving with its select pulled low");
  a_sck_half_min:
    assert property (sck_oe && $past(sck_oe) && $changed(sck_out) |=> $stable(sck_out))
    else $error("serial clock half period shorter than two cycles");
  a_irq_holds:
    assert property (irq && !(psel && penable) |=> irq)
    else $error("interrupt dropped without a register access");
  a_rdata_stands:
    assert property (psel && penable |=> $stable(prdata))
    else $error("read data changed after the access");
  a_unmapped_error:
    assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response does not match the address map");
endmodule : serial_port_assertions

bind serial_port serial_port_assertions serial_port_assertions_inst (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pslverr, .sck_out, .sck_oe, .mosi_oe,
  .miso_oe, .ss_n_in, .pins_alt_en, .ss_alt_en, .irq);

// >>> far_slave_model.sv
// Behavioural serial slave standing on the far side of the port in master mode.
// Assumes the bench drives its select and its mode to match the master.
module far_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  logic       hold_first = 1'b0;
  logic       last_bit = 1'b0;
  initial rx_byte = 8'h00;
  // A released data line shows the inverse of its last bit, never a stale copy.
  assign miso = sel_n ? ~last_bit : sh[7];
  always @(negedge sel_n)
  begin
    sh = tx_byte;
    hold_first = clock_phase;
  end
  always @(posedge sel_n) last_bit = sh[7];
  // Capture on the leading edge for phase 0, on the trailing edge for phase 1.
  always @(sck)
  begin
    if (!sel_n)
    begin
      if ((sck != clock_polarity) != clock_phase)
        rx_byte = {rx_byte[6:0], mosi};
      else if (hold_first)
        hold_first = 1'b0;
      else
        sh = {sh[6:0], 1'b0};
    end
  end
endmodule : far_slave_model

// >>> serial_port_tb.sv
// Self-checking bench: register access, master transfers against the far slave
// model, bench-driven slave transfers, overrun and mode fault.
module serial_port_tb
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ss_n_in = 1'b1;
  logic        tb_sck = 1'b0;
  logic        tb_mosi = 1'b0;
  logic        far_sel_n = 1'b1;
  logic        far_clock_polarity = 1'b0;
  logic        far_clock_phase = 1'b0;
  logic [7:0]  far_tx = 8'h00;
  logic        sck_q = 1'b0;
  int          run_len = 0;
  int          half_seen = 0;
  int          errors = 0;
  int          checks_done = 0;
  logic [7:0]  exp_q[$];
  int          divs[6] = '{4, 8, 16, 32, 64, 128};
  logic [2:0]  codes[6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
  wire  [31:0] prdata;
  wire         pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  wire         pins_alt_en, ss_alt_en, irq, far_miso;
  wire  [7:0]  far_rx;
  wire         sck_w = sck_oe ? sck_out : tb_sck;
  wire         mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire         miso_w = miso_oe ? miso_out : far_miso;

  serial_port serial_port_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe,
    .miso_in(miso_w), .miso_out, .miso_oe, .ss_n_in, .pins_alt_en, .ss_alt_en, .irq);
  far_slave_model far_slave_model_inst (.sck(sck_w), .mosi(mosi_w), .sel_n(far_sel_n),
    .clock_polarity(far_clock_polarity), .clock_phase(far_clock_phase), .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));

  always #5 pclk = ~pclk;

  // Length of the last serial clock half period, in pclk cycles.
  always @(posedge pclk)
  begin
    sck_q <= sck_out;
    if (sck_out !== sck_q)
    begin
      half_seen <= run_len;
      run_len <= 1;
    end
    else
      run_len <= run_len + 1;
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, exp);
  endtask : rdc

  // Bench acts as master in mode 0, half period 5 pclk, sampling the port's output.
  task automatic slave_byte(input logic [7:0] b, output logic [7:0] got);
    for (int k = 7; k >= 0; k--)
    begin
      tb_mosi <= b[k];
      repeat (5) @(posedge pclk);
      tb_sck <= 1'b1;
      got[k] = miso_w;
      repeat (5) @(posedge pclk);
      tb_sck <= 1'b0;
    end
    tb_mosi <= ~b[0];
    repeat (8) @(posedge pclk);
  endtask : slave_byte

  initial
  begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  c, d, t, got;
    int          n;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h8b1c5c72));
    rdc(ADDR_CTRL, {24'h0, CTRL_RESET});
    rdc(ADDR_STAT, {24'h0, STAT_RESET});
    chk({31'h0, pins_alt_en}, 32'h0);
    apb(1'b0, 8'h10, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    $display("Test reset and map done");
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($urandom);
      t = 8'($urandom);
      exp_q.push_back(t);
      far_tx <= t;
      far_clock_polarity <= i[0];
      far_clock_phase <= i[1];
      tb_sck <= i[0];
      c = {~i[0], 1'b0, codes[i][2], 1'b1, i[0], i[1], codes[i][1:0]};
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CTRL, c);
      wr(ADDR_CTRL, c | 8'h40);
      far_sel_n <= 1'b0;
      wr(ADDR_DATA, d);
      if (i == 5)
        wr(ADDR_DATA, ~d);
      n = 0;
      do
      begin
        apb(1'b0, ADDR_STAT, 8'h00, r, e);
        n++;
      end
      while (r[7] !== 1'b1 && n < 600);
      if (n >= 600)
      begin
        errors++;
        stop_test();
      end
      far_sel_n <= 1'b1;
      chk(r, {24'h0, (i == 5) ? 8'hc0 : 8'h80});
      chk({31'h0, irq}, {31'h0, ~i[0]});
      chk(half_seen, divs[i] / 2);
      chk({31'h0, sck_out}, {31'h0, i[0]});
      chk({27'h0, sck_oe, mosi_oe, miso_oe, pins_alt_en, ss_alt_en}, 32'h1b);
      rdc(ADDR_DATA, {24'h0, exp_q.pop_front()});
      chk({24'h0, far_rx}, {24'h0, d});
      rdc(ADDR_STAT, 32'h0);
      $display("Test master rate %0d done", divs[i]);
    end
    tb_sck <= 1'b0;
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'hd0);
    ss_n_in <= 1'b0;
    repeat (6) @(posedge pclk);
    ss_n_in <= 1'b1;
    chk({31'h0, irq}, 32'h1);
    rdc(ADDR_CTRL, 32'h80);
    rdc(ADDR_STAT, 32'h10);
    wr(ADDR_CTRL, 8'h00);
    rdc(ADDR_STAT, 32'h0);
    $display("Test mode fault done");
    wr(ADDR_STAT, 8'h02);
    wr(ADDR_CTRL, 8'h63);
    d = 8'($urandom);
    t = 8'($urandom);
    wr(ADDR_DATA, d);
    slave_byte(t, got);
    chk({24'h0, got}, {24'h0, d});
    wr(ADDR_DATA, ~t);
    slave_byte(8'($urandom), got);
    chk({24'h0, got}, {24'h0, t});
    rdc(ADDR_STAT, 32'ha2);
    rdc(ADDR_STAT, 32'h82);
    rdc(ADDR_DATA, {24'h0, t});
    rdc(ADDR_STAT, 32'h02);
    wr(ADDR_STAT, 8'h03);
    slave_byte(8'($urandom), got);
    rdc(ADDR_STAT, 32'h03);
    wr(ADDR_STAT, 8'h06);
    chk({31'h0, miso_oe}, 32'h0);
    $display("Test slave and overrun done");
    stop_test();
  end
endmodule : serial_port_tb
